// ---- core/jxu_pkg.sv ----
// Package for the jump execution unit: opcodes, widths and reset values.
package jxu_pkg;

  localparam int ADDR_W = 32;
  localparam int DATA_W = 16;
  localparam int REGSEL_W = 3;

  typedef enum logic [2:0]
  {
    JXU_OP_DEC_INDEX  = 3'h0,
    JXU_OP_INC_INDEX  = 3'h1,
    JXU_OP_UNCOND     = 3'h2,
    JXU_OP_LINK_GREG  = 3'h3,
    JXU_OP_STORE_MEM  = 3'h4,
    JXU_OP_SAVE_INDEX = 3'h5,
    JXU_OP_SAVE_XBASE = 3'h6,
    JXU_OP_SAVE_YIDX  = 3'h7
  } jxu_op_type;

  localparam logic [ADDR_W-1:0] PC_RESET   = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] PC_STEP    = 32'h0000_0001;
  localparam logic [DATA_W-1:0] INDEX_STEP = 16'h0001;
  localparam logic [DATA_W-1:0] INDEX_ZERO = 16'h0000;

endpackage

// ---- core/jxu_index_alu.sv ----
// Index adder for the conditional index jumps: step up or down and test for zero.
`timescale 1ns/100ps
`default_nettype none
module jxu_index_alu
#(
  parameter int W = jxu_pkg::DATA_W
)
(
  // Operand and direction.
  input  wire logic [W-1:0] index_in,
  input  wire logic         decrement,
  // Result.
  output logic [W-1:0]      index_out,
  output logic              is_zero
);
  import jxu_pkg::*;

  always_comb
  begin
    if (decrement)
      index_out = index_in - W'(INDEX_STEP);
    else
      index_out = index_in + W'(INDEX_STEP);
    is_zero = (index_out == W'(INDEX_ZERO));
  end
endmodule
`default_nettype wire

// ---- core/jxu_top.sv ----
// Jump execution unit: executes jump-class instructions in one cycle each.
`timescale 1ns/100ps
`default_nettype none
module jxu_top
(
  // Clock and reset.
  input  wire logic                         clk_sys,
  input  wire logic                         rst_n,
  // Decoded instruction.
  input  wire logic                         instr_valid,
  input  wire jxu_pkg::jxu_op_type          instr_op,
  input  wire logic [jxu_pkg::REGSEL_W-1:0] instr_reg_sel,
  input  wire logic [jxu_pkg::ADDR_W-1:0]   eff_addr,
  // Index register X as read from the register file.
  input  wire logic [jxu_pkg::DATA_W-1:0]   index_x_in,
  // Program counter.
  output logic [jxu_pkg::ADDR_W-1:0]        pc,
  // Register file write ports.
  output logic                              x_wr_en,
  output logic [jxu_pkg::DATA_W-1:0]        x_wr_data,
  output logic                              y_wr_en,
  output logic [jxu_pkg::DATA_W-1:0]        y_wr_data,
  output logic                              xb_wr_en,
  output logic [jxu_pkg::ADDR_W-1:0]        xb_wr_data,
  output logic                              greg_wr_en,
  output logic [jxu_pkg::REGSEL_W-1:0]      greg_wr_sel,
  output logic [jxu_pkg::ADDR_W-1:0]        greg_wr_data,
  // Memory write port.
  output logic                              mem_wr_en,
  output logic [jxu_pkg::ADDR_W-1:0]        mem_wr_addr,
  output logic [jxu_pkg::ADDR_W-1:0]        mem_wr_data,
  // Status.
  output logic                              jump_taken
);
  import jxu_pkg::*;

  logic rst_meta_r;
  logic rst_sync_r;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  logic [DATA_W-1:0] idx_new;
  logic              idx_zero;

  jxu_index_alu #(.W(DATA_W)) u_alu
  (
    .index_in  (index_x_in),
    .decrement (instr_op == JXU_OP_DEC_INDEX),
    .index_out (idx_new),
    .is_zero   (idx_zero)
  );

  logic [ADDR_W-1:0]   pc_r, pc_nxt;
  logic [ADDR_W-1:0]   pc_inc;
  logic                x_en_r, x_en_nxt, y_en_r, y_en_nxt;
  logic                xb_en_r, xb_en_nxt, g_en_r, g_en_nxt;
  logic                m_en_r, m_en_nxt, jt_r, jt_nxt;
  logic [DATA_W-1:0]   x_d_r, x_d_nxt, y_d_r, y_d_nxt;
  logic [ADDR_W-1:0]   xb_d_r, xb_d_nxt, g_d_r, g_d_nxt;
  logic [ADDR_W-1:0]   m_a_r, m_a_nxt, m_d_r, m_d_nxt;
  logic [REGSEL_W-1:0] g_s_r, g_s_nxt;

  // Saved values derive from the current PC, read before it is replaced.
  assign pc_inc = pc_r + PC_STEP;

  always_comb
  begin
    pc_nxt    = pc_r;
    x_en_nxt  = 1'b0;
    y_en_nxt  = 1'b0;
    xb_en_nxt = 1'b0;
    g_en_nxt  = 1'b0;
    m_en_nxt  = 1'b0;
    jt_nxt    = 1'b0;
    x_d_nxt   = x_d_r;
    y_d_nxt   = y_d_r;
    xb_d_nxt  = xb_d_r;
    g_d_nxt   = g_d_r;
    g_s_nxt   = g_s_r;
    m_a_nxt   = m_a_r;
    m_d_nxt   = m_d_r;
    if (instr_valid)
    begin
      jt_nxt = 1'b1;
      pc_nxt = eff_addr;
      unique case (instr_op)
        JXU_OP_DEC_INDEX, JXU_OP_INC_INDEX:
        begin
          x_en_nxt = 1'b1;
          x_d_nxt  = idx_new;
          if (!idx_zero)
          begin
            jt_nxt = 1'b0;
            pc_nxt = pc_inc;
          end
        end
        JXU_OP_UNCOND:
        begin
          jt_nxt = 1'b1;
        end
        JXU_OP_LINK_GREG:
        begin
          g_en_nxt = 1'b1;
          g_s_nxt  = instr_reg_sel;
          g_d_nxt  = pc_inc;
        end
        JXU_OP_STORE_MEM:
        begin
          m_en_nxt = 1'b1;
          m_a_nxt  = eff_addr;
          m_d_nxt  = pc_r;
        end
        JXU_OP_SAVE_INDEX:
        begin
          x_en_nxt = 1'b1;
          x_d_nxt  = pc_inc[DATA_W-1:0];
        end
        JXU_OP_SAVE_XBASE:
        begin
          xb_en_nxt = 1'b1;
          xb_d_nxt  = pc_r;
        end
        JXU_OP_SAVE_YIDX:
        begin
          y_en_nxt = 1'b1;
          y_d_nxt  = pc_inc[DATA_W-1:0];
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      pc_r    <= PC_RESET;
      x_en_r  <= 1'b0;
      y_en_r  <= 1'b0;
      xb_en_r <= 1'b0;
      g_en_r  <= 1'b0;
      m_en_r  <= 1'b0;
      jt_r    <= 1'b0;
      x_d_r   <= '0;
      y_d_r   <= '0;
      xb_d_r  <= '0;
      g_d_r   <= '0;
      g_s_r   <= '0;
      m_a_r   <= '0;
      m_d_r   <= '0;
    end
    else
    begin
      pc_r    <= pc_nxt;
      x_en_r  <= x_en_nxt;
      y_en_r  <= y_en_nxt;
      xb_en_r <= xb_en_nxt;
      g_en_r  <= g_en_nxt;
      m_en_r  <= m_en_nxt;
      jt_r    <= jt_nxt;
      x_d_r   <= x_d_nxt;
      y_d_r   <= y_d_nxt;
      xb_d_r  <= xb_d_nxt;
      g_d_r   <= g_d_nxt;
      g_s_r   <= g_s_nxt;
      m_a_r   <= m_a_nxt;
      m_d_r   <= m_d_nxt;
    end
  end

  assign pc           = pc_r;
  assign x_wr_en      = x_en_r;
  assign x_wr_data    = x_d_r;
  assign y_wr_en      = y_en_r;
  assign y_wr_data    = y_d_r;
  assign xb_wr_en     = xb_en_r;
  assign xb_wr_data   = xb_d_r;
  assign greg_wr_en   = g_en_r;
  assign greg_wr_sel  = g_s_r;
  assign greg_wr_data = g_d_r;
  assign mem_wr_en    = m_en_r;
  assign mem_wr_addr  = m_a_r;
  assign mem_wr_data  = m_d_r;
  assign jump_taken   = jt_r;

  uncond_loads_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_r)
    instr_valid && instr_op == JXU_OP_UNCOND |=> pc == $past(eff_addr) && jump_taken
      && !x_wr_en && !y_wr_en && !xb_wr_en && !greg_wr_en && !mem_wr_en)
    else $error("Unconditional jump did not load target alone.");

  any_jump_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_r)
    jump_taken |-> pc == $past(eff_addr))
    else $error("Taken jump without target in PC.");

  dec_index_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_r)
    instr_valid && instr_op == JXU_OP_DEC_INDEX |=> x_wr_en
      && x_wr_data == $past(index_x_in) - 16'h0001
      && jump_taken == (x_wr_data == 16'h0000))
    else $error("Decrement jump wrong.");

  inc_index_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_r)
    instr_valid && instr_op == JXU_OP_INC_INDEX |=> x_wr_en
      && x_wr_data == $past(index_x_in) + 16'h0001
      && jump_taken == (x_wr_data == 16'h0000))
    else $error("Increment jump wrong.");

  link_greg_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_r)
    instr_valid && instr_op == JXU_OP_LINK_GREG |=> greg_wr_en
      && greg_wr_sel == $past(instr_reg_sel) && greg_wr_data == $past(pc) + 32'h1)
    else $error("Linking jump return address wrong.");

  store_mem_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_r)
    instr_valid && instr_op == JXU_OP_STORE_MEM |=> mem_wr_en
      && mem_wr_data == $past(pc) && mem_wr_addr == $past(eff_addr))
    else $error("Store jump wrong.");

  save_x_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_r)
    instr_valid && instr_op == JXU_OP_SAVE_INDEX |=> x_wr_en
      && x_wr_data == 16'($past(pc) + 32'h1))
    else $error("Save-index value wrong.");

  save_xb_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_r)
    instr_valid && instr_op == JXU_OP_SAVE_XBASE |=> xb_wr_en
      && xb_wr_data == $past(pc) && pc == $past(eff_addr))
    else $error("Extended base save wrong.");

  save_y_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_r)
    instr_valid && instr_op == JXU_OP_SAVE_YIDX |=> y_wr_en
      && y_wr_data == 16'($past(pc) + 32'h1))
    else $error("Second index save wrong.");

  fall_through_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_r)
    instr_valid && (instr_op == JXU_OP_DEC_INDEX || instr_op == JXU_OP_INC_INDEX)
      && !idx_zero |=> pc == $past(pc) + 32'h1 && !jump_taken && x_wr_en)
    else $error("Nonzero index did not fall through.");

endmodule
`default_nettype wire

// ---- verification/jxu_partner.sv ----
// Register file model that holds index X and forwards writes to the unit.
`timescale 1ns/100ps
`default_nettype none
module jxu_partner
  import jxu_pkg::*;
(
  // Clock.
  input  wire logic                        clk_sys,
  // Preset from the bench.
  input  wire logic                        x_load,
  input  wire logic [jxu_pkg::DATA_W-1:0]  x_load_val,
  // Write port from the unit.
  input  wire logic                        x_wr_en,
  input  wire logic [jxu_pkg::DATA_W-1:0]  x_wr_data,
  // Forwarded index value.
  output logic [jxu_pkg::DATA_W-1:0]       index_x_in
);
  logic [DATA_W-1:0] x_r;

  // A write in flight is forwarded so back-to-back index jumps see it.
  assign index_x_in = x_load ? x_load_val : (x_wr_en ? x_wr_data : x_r);

  always_ff @(posedge clk_sys)
  begin
    x_r <= index_x_in;
  end
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
// Self-checking testbench for the jump execution unit.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import jxu_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic instr_valid = 1'b0;
  jxu_op_type instr_op = JXU_OP_UNCOND;
  logic [2:0] instr_reg_sel = 3'h0;
  logic [31:0] eff_addr = 32'h0;
  logic x_load = 1'b0;
  logic [15:0] x_load_val = 16'h0;
  logic [15:0] index_x_in, x_wr_data, y_wr_data;
  logic [31:0] pc, xb_wr_data, greg_wr_data, mem_wr_addr, mem_wr_data, epc;
  logic x_wr_en, y_wr_en, xb_wr_en, greg_wr_en, mem_wr_en, jump_taken;
  logic [2:0] greg_wr_sel;
  logic [4:0] any_en;
  int n_fail = 0;
  int tests_run = 0;

  assign any_en = {y_wr_en, xb_wr_en, x_wr_en, mem_wr_en, greg_wr_en};

  jxu_top dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .instr_valid(instr_valid),
    .instr_op(instr_op), .instr_reg_sel(instr_reg_sel), .eff_addr(eff_addr),
    .index_x_in(index_x_in), .pc(pc), .x_wr_en(x_wr_en), .x_wr_data(x_wr_data),
    .y_wr_en(y_wr_en), .y_wr_data(y_wr_data), .xb_wr_en(xb_wr_en),
    .xb_wr_data(xb_wr_data), .greg_wr_en(greg_wr_en), .greg_wr_sel(greg_wr_sel),
    .greg_wr_data(greg_wr_data), .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr),
    .mem_wr_data(mem_wr_data), .jump_taken(jump_taken));

  jxu_partner part_u (.clk_sys(clk_sys), .x_load(x_load), .x_load_val(x_load_val),
    .x_wr_en(x_wr_en), .x_wr_data(x_wr_data), .index_x_in(index_x_in));

  initial
  begin
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s exp %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report;
    $display("Checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Presents one instruction at a falling edge; outputs are settled at the next one.
  task automatic step(input jxu_op_type op, input logic [31:0] ea);
    instr_valid = 1'b1;
    instr_op = op;
    eff_addr = ea;
    @(negedge clk_sys);
  endtask

  task automatic idle(input string name);
    instr_valid = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk("pc idle", pc, epc);
    chk("en idle", 32'({any_en, jump_taken}), 32'h0);
    $display("test %s done", name);
  endtask

  task automatic preset(input logic [15:0] v);
    x_load = 1'b1;
    x_load_val = v;
    @(negedge clk_sys);
    x_load = 1'b0;
  endtask

  task automatic idx(input jxu_op_type op, input logic [31:0] ea, input logic [15:0] ex);
    logic tk;
    tk = (ex == 16'h0);
    epc = tk ? ea : epc + 32'h1;
    step(op, ea);
    chk("x_wr_data", 32'(x_wr_data), 32'(ex));
    chk("x_wr_en", 32'(any_en), 32'h4);
    chk("pc", pc, epc);
    chk("jump_taken", 32'(jump_taken), 32'(tk));
  endtask

  task automatic t_dec;
    preset(16'h0001);
    idx(JXU_OP_DEC_INDEX, 32'h0123_0040, 16'h0000);
    idx(JXU_OP_DEC_INDEX, 32'h0200_0000, 16'hffff);
    idle("dec");
  endtask

  task automatic t_inc;
    preset(16'hffff);
    idx(JXU_OP_INC_INDEX, 32'h0456_0080, 16'h0000);
    idx(JXU_OP_INC_INDEX, 32'h0300_0000, 16'h0001);
    idle("inc");
  endtask

  task automatic t_uncond;
    epc = 32'h7fff_0010;
    step(JXU_OP_UNCOND, epc);
    chk("pc", pc, epc);
    chk("jump_taken", 32'(jump_taken), 32'h1);
    chk("enables", 32'(any_en), 32'h0);
    idle("uncond");
  endtask

  // Checks the state that reset leaves before any instruction is given.
  task automatic t_reset;
    chk("pc reset", pc, PC_RESET);
    chk("en reset", 32'({any_en, jump_taken}), 32'h0);
    $display("test reset done");
  endtask

  task automatic t_saves;
    logic [31:0] p, d, ev;
    for (int o = 3; o <= 7; o++)
    begin
      p = epc;
      epc = 32'h0100_0000 + 32'(o);
      instr_reg_sel = 3'(o);
      step(jxu_op_type'(3'(o)), epc);
      case (o)
        3: d = greg_wr_data;
        4: d = mem_wr_data;
        5: d = 32'(x_wr_data);
        6: d = xb_wr_data;
        default: d = 32'(y_wr_data);
      endcase
      ev = (o == 5 || o == 7) ? 32'(16'(p + 32'h1)) : ((o == 3) ? p + 32'h1 : p);
      chk("saved", d, ev);
      chk("save en", 32'(any_en), 32'h1 << (o - 3));
      chk("pc", pc, epc);
      chk("jump_taken", 32'(jump_taken), 32'h1);
      if (o == 3)
        chk("greg sel", 32'(greg_wr_sel), 32'h3);
      if (o == 4)
        chk("mem addr", mem_wr_addr, epc);
    end
    idle("saves");
  endtask

  initial
  begin
    #20000;
    n_fail++;
    final_report();
  end

  initial
  begin
    epc = 32'h0;
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    t_reset();
    t_dec();
    t_inc();
    t_uncond();
    t_saves();
    final_report();
  end
endmodule
`default_nettype wire
